// ===== src/ssm_map.svh
// constants for the special-mode serial channel
`ifndef SSM_MAP_SVH
`define SSM_MAP_SVH
`define SSM_MODE_SYNC 3'h1
`define SSM_MODE_BUS 3'h6
`define SSM_SYNC_BITS 4'h8
`define SSM_OVR_BIT 4'h7
`define SSM_BUS_BITS 4'h9
`define SSM_SYNC_EDGES 5'h10
`define SSM_MID_TICK 4'h8
`define SSM_LATE_TICK 4'hf
`define SSM_LAST_TICK 4'hf
`define SSM_TE_RST 1'b0
`define SSM_LINE_IDLE 1'b1
`endif

// ===== src/ssm_pkg.sv
// types for the special-mode serial channel
package ssm_pkg;
  typedef enum logic [2:0] {TX_IDLE, TX_SYNC, TX_START, TX_DATA, TX_STOP} ssm_tx_st_t;
  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} ssm_rx_st_t;
  typedef struct packed {
    ssm_tx_st_t tx_st;
    ssm_rx_st_t rx_st;
    logic rxd_s1;
    logic rxd_s2;
    logic rxd_s3;
    logic clk_s1;
    logic clk_s2;
    logic clk_s3;
    logic [7:0] div_cnt;
    logic div_tick;
    logic [3:0] tx_tick;
    logic [3:0] rx_tick;
    logic [3:0] tx_bits;
    logic [3:0] rx_bits;
    logic [4:0] edges;
    logic [8:0] tx_shift;
    logic [8:0] rx_shift;
    logic tx_line;
    logic sclk;
    logic [8:0] rx_buffer;
    logic rx_complete;
    logic overrun;
    logic framing;
    logic te;
    logic tx_irq;
    logic rx_irq;
    logic collision;
  } ssm_state_t;
endpackage

// ===== src/ssm_serial.sv
// special-mode serial channel: clocked multi-slave mode and bus mode
`timescale 1ns/1ps
`include "ssm_map.svh"

module ssm_fifo #(
  parameter int WIDTH = 9,
  parameter int DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic in_valid_i,
  output logic in_ready_o,
  input wire logic [WIDTH-1:0] in_data_i,
  output logic out_valid_o,
  input wire logic out_ready_i,
  output logic [WIDTH-1:0] out_data_o
);
  localparam int AW = $clog2(DEPTH);
  typedef struct packed {
    logic [DEPTH-1:0][WIDTH-1:0] mem;
    logic [AW:0] wr;
    logic [AW:0] rd;
  } ssm_fifo_st_t;
  ssm_fifo_st_t s;
  ssm_fifo_st_t nxt;
  logic full;
  logic empty;

  // pointer compare with wrap bit
  assign empty = s.wr == s.rd;
  assign full = (s.wr[AW-1:0] == s.rd[AW-1:0]) && (s.wr[AW] != s.rd[AW]);
  assign in_ready_o = !full;
  assign out_valid_o = !empty;
  assign out_data_o = s.mem[s.rd[AW-1:0]];

  // push and pop
  always_comb begin
    nxt = s;
    if (in_valid_i && !full) begin
      nxt.mem[s.wr[AW-1:0]] = in_data_i;
      nxt.wr = s.wr + 1'b1;
    end
    if (out_ready_i && !empty) begin
      nxt.rd = s.rd + 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
    end else begin
      s <= nxt;
    end
  end
endmodule

module ssm_serial #(
  parameter int CHANNEL = 2,
  parameter int FIFO_DEPTH = 16
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic [2:0] serial_mode_field_i,
  input wire logic clk_source_dir_i,
  input wire logic clk_polarity_sel_i,
  input wire logic clk_phase_sel_i,
  input wire logic line_polarity_invert_i,
  input wire logic tx_output_format_i,
  input wire logic [7:0] rate_div_i,
  input wire logic tx_enable_set_i,
  input wire logic tx_enable_clr_i,
  input wire logic rx_enable_bit_i,
  input wire logic collision_sample_sel_i,
  input wire logic tx_enable_autoclear_i,
  input wire logic tx_start_cond_sel_i,
  input wire logic collision_en_ch0_i,
  input wire logic collision_en_ch1_i,
  input wire logic ch0_tx_irq_cause_i,
  input wire logic ch1_tx_irq_cause_i,
  input wire logic ch2_tx_irq_cause_i,
  input wire logic [8:0] tx_data_i,
  input wire logic tx_valid_i,
  output logic tx_ready_o,
  input wire logic rx_read_i,
  output logic [8:0] rx_buffer_o,
  output logic rx_complete_o,
  output logic overrun_flag_o,
  output logic framing_err_flag_o,
  output logic parity_err_flag_o,
  output logic error_summary_flag_o,
  output logic tx_shift_empty_o,
  output logic tx_buffer_empty_o,
  output logic tx_enable_bit_o,
  output logic tx_irq_o,
  output logic rx_irq_o,
  output logic collision_irq_o,
  input wire logic rxd_i,
  output logic txd_o,
  output logic txd_oe_o,
  input wire logic sclk_i,
  output logic sclk_o,
  output logic sclk_oe_o
);
  ssm_pkg::ssm_state_t s;
  ssm_pkg::ssm_state_t nxt;
  logic fifo_valid;
  logic [8:0] fifo_data;
  logic pop;
  logic sync_md;
  logic bus_md;
  logic master;
  logic irq_cause;
  logic coll_en;
  logic open_drain;
  logic inv;
  logic rx_lvl;
  logic pin_lvl;
  logic ext_rise;
  logic ext_fall;
  logic tog;
  logic rise_evt;
  logic fall_evt;
  logic sample_evt;
  logic drive_evt;
  logic bus_tick;
  logic rx_start_edge;

  // transmit words queue ahead of the transmit buffer
  ssm_fifo #(.WIDTH(9), .DEPTH(FIFO_DEPTH)) u_txq (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .in_valid_i(tx_valid_i),
    .in_ready_o(tx_ready_o),
    .in_data_i(tx_data_i),
    .out_valid_o(fifo_valid),
    .out_ready_i(pop),
    .out_data_o(fifo_data)
  );

  // mode decode and per-channel selections
  assign sync_md = serial_mode_field_i == `SSM_MODE_SYNC;
  assign bus_md = serial_mode_field_i == `SSM_MODE_BUS;
  assign master = !clk_source_dir_i;
  assign irq_cause = (CHANNEL == 2) ? ch2_tx_irq_cause_i :
    (CHANNEL == 1) ? ch1_tx_irq_cause_i : ch0_tx_irq_cause_i;
  assign coll_en = (CHANNEL == 2) ? 1'b1 :
    (CHANNEL == 1) ? collision_en_ch1_i : collision_en_ch0_i;
  assign open_drain = (CHANNEL == 2) ? 1'b1 : tx_output_format_i;
  assign inv = bus_md && line_polarity_invert_i;
  assign rx_lvl = s.rxd_s2 ^ inv;
  assign pin_lvl = s.tx_line ^ inv;

  // transfer clock edges: internal toggle or synchronised pin
  assign ext_rise = s.clk_s2 && !s.clk_s3;
  assign ext_fall = !s.clk_s2 && s.clk_s3;
  assign tog = master && (s.tx_st == ssm_pkg::TX_SYNC) && s.div_tick
    && (s.edges != `SSM_SYNC_EDGES);
  assign rise_evt = master ? (tog && !s.sclk) : ext_rise;
  assign fall_evt = master ? (tog && s.sclk) : ext_fall;
  // four polarity/phase variants pick which edge samples
  assign sample_evt = (clk_polarity_sel_i ^ clk_phase_sel_i) ? fall_evt : rise_evt;
  assign drive_evt = (clk_polarity_sel_i ^ clk_phase_sel_i) ? rise_evt : fall_evt;
  assign bus_tick = clk_source_dir_i ? ext_rise : s.div_tick;
  assign rx_start_edge = !rx_lvl && (s.rxd_s3 ^ inv);

  // next-state logic for both modes
  always_comb begin
    nxt = s;
    pop = 1'b0;
    nxt.rxd_s1 = rxd_i;
    nxt.rxd_s2 = s.rxd_s1;
    nxt.rxd_s3 = s.rxd_s2;
    nxt.clk_s1 = sclk_i;
    nxt.clk_s2 = s.clk_s1;
    nxt.clk_s3 = s.clk_s2;
    nxt.tx_irq = 1'b0;
    nxt.rx_irq = 1'b0;
    nxt.collision = 1'b0;
    nxt.div_tick = 1'b0;
    nxt.div_cnt = s.div_cnt + 8'h01;
    if (s.div_cnt >= rate_div_i) begin
      nxt.div_cnt = 8'h00;
      nxt.div_tick = 1'b1;
    end
    if (!rx_enable_bit_i) begin
      nxt.overrun = 1'b0;
      nxt.framing = 1'b0;
    end
    if (rx_read_i) begin
      nxt.rx_complete = 1'b0;
    end
    if (tx_enable_clr_i) begin
      nxt.te = 1'b0;
    end
    if (tx_enable_set_i) begin
      nxt.te = 1'b1;
    end
    case (s.tx_st)
      ssm_pkg::TX_IDLE: begin
        if (sync_md) begin
          nxt.sclk = !clk_polarity_sel_i;
        end
        // no flow-control pin gates the start in either mode
        if (sync_md && s.te && fifo_valid) begin
          pop = 1'b1;
          nxt.tx_st = ssm_pkg::TX_SYNC;
          nxt.tx_shift = fifo_data;
          nxt.tx_line = fifo_data[0];
          nxt.rx_bits = 4'h0;
          nxt.edges = 5'h00;
          // restart divider so the first edge comes a full period after bit 0 settles
          nxt.div_cnt = 8'h00;
          nxt.div_tick = 1'b0;
          nxt.tx_irq = !irq_cause;
        end else if (bus_md && s.te && fifo_valid
            && (!tx_start_cond_sel_i || rx_start_edge)) begin
          pop = 1'b1;
          nxt.tx_st = ssm_pkg::TX_START;
          nxt.tx_shift = fifo_data;
          nxt.tx_line = 1'b0;
          nxt.tx_tick = 4'h0;
          nxt.tx_bits = 4'h0;
          nxt.tx_irq = !irq_cause;
        end
      end
      ssm_pkg::TX_SYNC: begin
        if (tog) begin
          nxt.sclk = !s.sclk;
          nxt.edges = s.edges + 5'h01;
        end
        if (drive_evt && (s.rx_bits != 4'h0) && (s.rx_bits != `SSM_SYNC_BITS)) begin
          nxt.tx_shift = {1'b0, s.tx_shift[8:1]};
          nxt.tx_line = s.tx_shift[1];
        end
        if (sample_evt && (s.rx_bits != `SSM_SYNC_BITS)) begin
          nxt.rx_bits = s.rx_bits + 4'h1;
          nxt.rx_shift = {s.rxd_s2, s.rx_shift[8:1]};
          if (rx_enable_bit_i && s.rx_complete && !rx_read_i
              && (s.rx_bits + 4'h1 == `SSM_OVR_BIT)) begin
            nxt.overrun = 1'b1;
          end
          if (rx_enable_bit_i && (s.rx_bits + 4'h1 == `SSM_SYNC_BITS)) begin
            // on overrun the buffer keeps stale data and no request fires
            if (!nxt.overrun) begin
              nxt.rx_buffer = {1'b0, s.rxd_s2, s.rx_shift[8:2]};
              nxt.rx_complete = 1'b1;
              nxt.rx_irq = 1'b1;
            end
          end
        end
        if (!sync_md || (master ? (s.edges == `SSM_SYNC_EDGES)
            : (sample_evt && (s.rx_bits + 4'h1 == `SSM_SYNC_BITS)))) begin
          nxt.tx_st = ssm_pkg::TX_IDLE;
          nxt.tx_irq = irq_cause;
        end
      end
      default: begin
        // sixteen ticks per bus bit: start, 9 data, stop
        if (!bus_md) begin
          nxt.tx_st = ssm_pkg::TX_IDLE;
          nxt.tx_line = `SSM_LINE_IDLE;
        end else if (bus_tick) begin
          nxt.tx_tick = s.tx_tick + 4'h1;
          if (s.tx_tick == (collision_sample_sel_i ? `SSM_LATE_TICK : `SSM_MID_TICK)
              && coll_en && (s.tx_line != rx_lvl)) begin
            nxt.collision = 1'b1;
            if (tx_enable_autoclear_i && !tx_enable_set_i) begin
              nxt.te = 1'b0;
            end
          end
          if (s.tx_tick == `SSM_LAST_TICK) begin
            case (s.tx_st)
              ssm_pkg::TX_START: begin
                nxt.tx_st = ssm_pkg::TX_DATA;
                nxt.tx_line = s.tx_shift[0];
              end
              ssm_pkg::TX_DATA: begin
                nxt.tx_bits = s.tx_bits + 4'h1;
                nxt.tx_shift = {1'b0, s.tx_shift[8:1]};
                if (s.tx_bits + 4'h1 == `SSM_BUS_BITS) begin
                  nxt.tx_st = ssm_pkg::TX_STOP;
                  nxt.tx_line = `SSM_LINE_IDLE;
                end else begin
                  nxt.tx_line = s.tx_shift[1];
                end
              end
              default: begin
                nxt.tx_st = ssm_pkg::TX_IDLE;
                nxt.tx_irq = irq_cause;
              end
            endcase
          end
        end
      end
    endcase
    // bus-mode receiver, mid-bit sampling
    case (s.rx_st)
      ssm_pkg::RX_IDLE: begin
        if (bus_md && rx_enable_bit_i && rx_start_edge) begin
          nxt.rx_st = ssm_pkg::RX_START;
          nxt.rx_tick = 4'h0;
          nxt.rx_bits = 4'h0;
        end
      end
      default: begin
        if (!bus_md || !rx_enable_bit_i) begin
          nxt.rx_st = ssm_pkg::RX_IDLE;
        end else if (bus_tick) begin
          nxt.rx_tick = s.rx_tick + 4'h1;
          if (s.rx_tick == `SSM_MID_TICK) begin
            case (s.rx_st)
              ssm_pkg::RX_START: begin
                if (rx_lvl) begin
                  nxt.rx_st = ssm_pkg::RX_IDLE;
                end
              end
              ssm_pkg::RX_DATA: begin
                nxt.rx_shift = {rx_lvl, s.rx_shift[8:1]};
                nxt.rx_bits = s.rx_bits + 4'h1;
              end
              default: begin
                nxt.rx_st = ssm_pkg::RX_IDLE;
                nxt.framing = !rx_lvl;
                if (s.rx_complete && !rx_read_i) begin
                  nxt.overrun = 1'b1;
                end else begin
                  nxt.rx_buffer = s.rx_shift;
                  nxt.rx_complete = 1'b1;
                  nxt.rx_irq = 1'b1;
                end
              end
            endcase
          end else if (s.rx_tick == `SSM_LAST_TICK) begin
            if (s.rx_st == ssm_pkg::RX_START) begin
              nxt.rx_st = ssm_pkg::RX_DATA;
            end else if (s.rx_st == ssm_pkg::RX_DATA && s.rx_bits == `SSM_BUS_BITS) begin
              nxt.rx_st = ssm_pkg::RX_STOP;
            end
          end
        end
      end
    endcase
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      s <= '0;
      s.rxd_s1 <= 1'b1;
      s.rxd_s2 <= 1'b1;
      s.rxd_s3 <= 1'b1;
      s.tx_line <= `SSM_LINE_IDLE;
      s.sclk <= 1'b1;
      s.te <= `SSM_TE_RST;
    end else begin
      s <= nxt;
    end
  end

  // status and pin outputs
  assign rx_buffer_o = s.rx_buffer;
  assign rx_complete_o = s.rx_complete;
  assign overrun_flag_o = s.overrun;
  assign framing_err_flag_o = s.framing;
  assign parity_err_flag_o = 1'b0;
  assign error_summary_flag_o = s.overrun || s.framing;
  assign tx_shift_empty_o = s.tx_st == ssm_pkg::TX_IDLE;
  assign tx_buffer_empty_o = !fifo_valid;
  assign tx_enable_bit_o = s.te;
  assign tx_irq_o = s.tx_irq;
  assign rx_irq_o = s.rx_irq;
  assign collision_irq_o = s.collision;
  assign txd_o = open_drain ? 1'b0 : pin_lvl;
  assign txd_oe_o = open_drain ? !pin_lvl : 1'b1;
  assign sclk_o = s.sclk;
  assign sclk_oe_o = sync_md && master;

  default clocking dc @(posedge clk_i); endclocking
  default disable iff (rst_i);

  clk_role_a: assert property (sync_md |-> sclk_oe_o == !clk_source_dir_i)
    else $error("clock drive does not follow role");
  ovr_keep_a: assert property (rx_irq_o |-> !$past(s.overrun, 1) || !sync_md)
    else $error("receive request raised on overrun");
  ovr_seventh_a: assert property ($rose(s.overrun) && sync_md |-> s.rx_bits == 4'h7)
    else $error("overrun not at seventh bit");
  drive_edge_a: assert property (s.tx_st == ssm_pkg::TX_SYNC && $past(s.tx_st) == ssm_pkg::TX_SYNC
    && $changed(s.tx_line) |-> $past(drive_evt))
    else $error("data changed off the drive edge");
  idle_clk_a: assert property (s.tx_st == ssm_pkg::TX_SYNC && nxt.tx_st == ssm_pkg::TX_IDLE
    && master && sync_md |=> sclk_o == !clk_polarity_sel_i)
    else $error("master clock not idle after transfer");
  coll_level_a: assert property (collision_irq_o |-> $past(s.tx_line != rx_lvl))
    else $error("collision without level mismatch");
  coll_enable_a: assert property (collision_irq_o |-> $past(coll_en))
    else $error("collision while detection disabled");
  auto_clear_a: assert property (collision_irq_o && $past(tx_enable_autoclear_i)
    && !$past(tx_enable_set_i) |-> !tx_enable_bit_o)
    else $error("transmit enable not auto cleared");
  nine_bits_a: assert property ($rose(s.tx_st == ssm_pkg::TX_STOP) |-> s.tx_bits == 4'h9
    && s.tx_line)
    else $error("bus character length wrong");
  open_drain_a: assert property (CHANNEL == 2 |-> !(txd_oe_o && txd_o))
    else $error("channel 2 drove the line high");

  sync_done_c: cover property (sync_md && rx_irq_o);
  bus_done_c: cover property (bus_md && rx_irq_o);
  collision_c: cover property (collision_irq_o);
  overrun_c: cover property ($rose(s.overrun));
endmodule

// ===== testbench/ssm_peer.sv
// far-side serial peer: shared pulled-up data line and external transfer clock
`timescale 1ns/1ps
module ssm_peer (
  input wire logic txd_i,
  input wire logic txd_oe_i,
  input wire logic jam_i,
  input wire logic pol_i,
  input wire logic go_i,
  output logic rxd_o,
  output logic sclk_o
);
  logic clk_q = 1'b1;
  logic run = 1'b0;
  // pulled-up line: a driven low or a jam from another node wins
  assign rxd_o = !(txd_oe_i && !txd_i) && !jam_i;
  // clock stands at the inverse of polarity between frames
  assign sclk_o = run ? clk_q : !pol_i;
  // one frame of 16 edges at 160 ns period, same variant as the channel
  always @(posedge go_i) begin
    clk_q = !pol_i;
    run = 1'b1;
    repeat (16) begin
      #80;
      clk_q = ~clk_q;
    end
    run = 1'b0;
  end
endmodule

// ===== testbench/testbench.sv
// self-checking bench for the special-mode serial channel
`timescale 1ns/1ps
module testbench;
  logic clk_i = 1'b0;
  logic rst_i = 1'b1;
  logic [2:0] mode = 3'h0;
  logic dir = 1'b0;
  logic pol = 1'b0;
  logic ph = 1'b0;
  logic inv = 1'b0;
  logic [7:0] div = 8'h03;
  logic te_set = 1'b0;
  logic te_clr = 1'b0;
  logic rx_en = 1'b1;
  logic csel = 1'b0;
  logic autoclr = 1'b0;
  logic en01 = 1'b0;
  logic cause = 1'b0;
  logic [8:0] tx_data = 9'h000;
  logic tx_valid = 1'b0;
  logic rx_read = 1'b0;
  logic jam = 1'b0;
  logic go = 1'b0;
  logic tx_output_format = 1'b0;
  logic tx_start_cond_sel = 1'b0;
  logic no_read = 1'b0;
  logic rd_pend = 1'b0;
  logic [8:0] rx_buffer_o;
  logic tx_ready_o, rx_complete_o, overrun_flag_o, framing_err_flag_o, parity_err_flag_o;
  logic error_summary_flag_o, tx_shift_empty_o, tx_buffer_empty_o, tx_enable_bit_o;
  logic tx_irq_o, rx_irq_o, collision_irq_o, txd_o, txd_oe_o, sclk_o, sclk_oe_o;
  logic rxd, peer_sclk;
  int err_total = 0;
  int check_count = 0;
  int cycles = 0;
  int coll_seen = 0;
  int txi_seen = 0;
  logic [8:0] exp_q[$];
  logic [8:0] w;
  int t0;

  ssm_serial #(.CHANNEL(2), .FIFO_DEPTH(16)) i_ssm_serial (
    .clk_i, .rst_i,
    .serial_mode_field_i(mode),
    .clk_source_dir_i(dir),
    .clk_polarity_sel_i(pol),
    .clk_phase_sel_i(ph),
    .line_polarity_invert_i(inv),
    .tx_output_format_i(tx_output_format),
    .rate_div_i(div),
    .tx_enable_set_i(te_set),
    .tx_enable_clr_i(te_clr),
    .rx_enable_bit_i(rx_en),
    .collision_sample_sel_i(csel),
    .tx_enable_autoclear_i(autoclr),
    .tx_start_cond_sel_i(tx_start_cond_sel),
    .collision_en_ch0_i(en01),
    .collision_en_ch1_i(en01),
    .ch0_tx_irq_cause_i(1'b0),
    .ch1_tx_irq_cause_i(1'b0),
    .ch2_tx_irq_cause_i(cause),
    .tx_data_i(tx_data),
    .tx_valid_i(tx_valid),
    .tx_ready_o,
    .rx_read_i(rx_read),
    .rx_buffer_o, .rx_complete_o, .overrun_flag_o, .framing_err_flag_o,
    .parity_err_flag_o, .error_summary_flag_o, .tx_shift_empty_o, .tx_buffer_empty_o,
    .tx_enable_bit_o, .tx_irq_o, .rx_irq_o, .collision_irq_o,
    .rxd_i(rxd),
    .txd_o, .txd_oe_o,
    .sclk_i(sclk_oe_o ? sclk_o : peer_sclk),
    .sclk_o, .sclk_oe_o
  );

  ssm_peer i_ssm_peer (.txd_i(txd_o), .txd_oe_i(txd_oe_o), .jam_i(jam), .pol_i(pol),
    .go_i(go), .rxd_o(rxd), .sclk_o(peer_sclk));

  // clock and hang guard
  always #10 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cycles++;
    if (cycles == 60000) begin
      err_total++;
      close_out();
    end
  end

  task automatic check(input logic [8:0] seen, input logic [8:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks=%0d mismatches=%0d", check_count, err_total);
    if (err_total == 0 && check_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask

  // watch outputs; each received word takes the oldest note
  always @(posedge clk_i) begin
    if (collision_irq_o === 1'b1) coll_seen++;
    if (tx_irq_o === 1'b1) begin
      txi_seen++;
      check(tx_shift_empty_o, cause);
    end
    if (rx_irq_o === 1'b1) begin
      if (exp_q.size() == 0) check(9'h001, 9'h000);
      else check(rx_buffer_o, exp_q.pop_front());
      check(rx_complete_o, 1'b1);
      rd_pend = 1'b1;
    end
  end
  // software read of each word unless held off
  always @(negedge clk_i) begin
    rx_read = rd_pend && !no_read;
    rd_pend = 1'b0;
  end

  // queue one word; the note keeps only what the mode carries
  task automatic push(input logic [8:0] d, input bit note);
    int n;
    @(negedge clk_i);
    tx_data = d;
    tx_valid = 1'b1;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (tx_ready_o !== 1'b1 && n < 5000);
    if (tx_ready_o !== 1'b1) err_total++;
    if (note) exp_q.push_back(mode == 3'h1 ? d & 9'h0ff : d);
    @(negedge clk_i);
    tx_valid = 1'b0;
  endtask

  task automatic pulse_te(input bit clr);
    @(negedge clk_i);
    if (clr) te_clr = 1'b1;
    else te_set = 1'b1;
    @(negedge clk_i);
    te_clr = 1'b0;
    te_set = 1'b0;
  endtask

  task automatic wait_idle();
    int n;
    n = 0;
    repeat (4) @(negedge clk_i);
    while (!(tx_buffer_empty_o === 1'b1 && tx_shift_empty_o === 1'b1) && n < 4000) begin
      @(negedge clk_i);
      n++;
    end
    repeat (40) @(negedge clk_i);
    check(tx_shift_empty_o, 1'b1);
    check(tx_buffer_empty_o, 1'b1);
  endtask

  initial begin
    void'($urandom(32'h888b));
    repeat (20) @(negedge clk_i);
    rst_i = 1'b0;
    pulse_te(0);
    // clocked mode: both roles, all four clock variants, random bytes
    mode = 3'h1;
    for (int i = 0; i < 8; i++) begin
      @(negedge clk_i);
      {dir, pol, ph} = 3'(i);
      tx_output_format = 1'($urandom);
      w = 9'($urandom);
      push(w, 1);
      if (dir) begin
        repeat (6) @(negedge clk_i);
        go = 1'b1;
        @(negedge clk_i);
        go = 1'b0;
      end
      wait_idle();
      check(sclk_oe_o, !dir);
      check(txd_o, 1'b0);
      if (!dir) check(sclk_o, !pol);
    end
    $display("test clocked variants done");
    // back-to-back words without a read: overrun on the second
    {dir, pol, ph} = 3'h0;
    no_read = 1'b1;
    push(9'($urandom), 1);
    push(9'($urandom), 0);
    wait_idle();
    check(overrun_flag_o, 1'b1);
    check(error_summary_flag_o, 1'b1);
    check(rx_complete_o, 1'b1);
    rx_en = 1'b0;
    @(negedge clk_i);
    rx_en = 1'b1;
    no_read = 1'b0;
    rd_pend = 1'b1;
    repeat (3) @(negedge clk_i);
    check(overrun_flag_o, 1'b0);
    check(rx_complete_o, 1'b0);
    $display("test overrun done");
    // bus mode: 9-bit characters, both line polarities, both transmit causes
    mode = 3'h6;
    div = 8'h00;
    for (int i = 0; i < 4; i++) begin
      {inv, cause} = 2'(i);
      t0 = txi_seen;
      push(9'($urandom), 1);
      wait_idle();
      check(9'(txi_seen - t0), 9'h001);
      check(framing_err_flag_o, 1'b0);
      check(parity_err_flag_o, 1'b0);
    end
    $display("test bus frames done");
    // fill the queue with transmit held off, then drain it
    inv = 1'b0;
    // mid-run reset returns enable, queue and flags to rest
    rst_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check(tx_enable_bit_o, 1'b0);
    check(tx_buffer_empty_o, 1'b1);
    check(rx_complete_o, 1'b0);
    rst_i = 1'b0;
    pulse_te(1);
    for (int i = 0; i < 16; i++) push(9'($urandom), 1);
    repeat (2) @(negedge clk_i);
    check(tx_ready_o, 1'b0);
    check(tx_buffer_empty_o, 1'b0);
    pulse_te(0);
    wait_idle();
    $display("test queue fill done");
    // start on a receive edge: the word waits until the line falls
    rx_en = 1'b0;
    tx_start_cond_sel = 1'b1;
    push(9'h155, 0);
    repeat (20) @(negedge clk_i);
    check(tx_shift_empty_o, 1'b1);
    jam = 1'b1;
    repeat (8) @(negedge clk_i);
    check(tx_shift_empty_o, 1'b0);
    wait_idle();
    tx_start_cond_sel = 1'b0;
    $display("test start condition done");
    // a jammed line collides; autoclear drops transmit enable
    autoclr = 1'b1;
    for (int i = 0; i < 2; i++) begin
      csel = 1'(i);
      en01 = 1'(i);
      pulse_te(0);
      t0 = coll_seen;
      push(9'h1ff, 0);
      wait_idle();
      check(coll_seen > t0, 1'b1);
      check(tx_enable_bit_o, 1'b0);
    end
    jam = 1'b0;
    $display("test collision done");
    close_out();
  end
endmodule
